// File: csp_cfg.svh
// Purpose: Constants of the converter serial port
// Assumes: Included by the package and the design file
// Notes: Definitions only
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// ----------------------------------------
// Word and command layout
// ----------------------------------------
`define CSP_WORD_W 24
`define CSP_CNT_W 5
`define CSP_ADDR_W 4
`define CSP_CMD_W 8
`define CSP_BIT_HI 5
`define CSP_BIT_LO 4
`define CSP_EXIT_CNT 5'h07

// ----------------------------------------
// Register addresses and lengths
// ----------------------------------------
`define CSP_ADDR_DATA 4'h1
`define CSP_ADDR_MODE 4'h2
`define CSP_ADDR_FILTER 4'h3
`define CSP_ADDR_TRIM 4'h4
`define CSP_LEN_CMD 5'h08
`define CSP_LEN_MODE 5'h10
`define CSP_LEN_FILTER 5'h18
`define CSP_LEN_TRIM 5'h08
`define CSP_LEN_DEFAULT 5'h18

// ----------------------------------------
// Reset values and buffer
// ----------------------------------------
`define CSP_PIN_N 5
`define CSP_PIN_RST 5'h1f
`define CSP_DATA_RST 24'h00_0000
`define CSP_FIFO_DEPTH 16
`define CSP_FIFO_AW 4

`endif

// File: csp_pkg.sv
// Purpose: Types of the converter serial port
// Assumes: csp_cfg.svh holds the constants
// Notes: No imports; use csp_pkg::name
`include "csp_cfg.svh"

package csp_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      CSP_ST_CMD = 4'h1,
      CSP_ST_WRITE = 4'h2,
      CSP_ST_READ = 4'h4,
      CSP_ST_CONT = 4'h8
   } csp_state_t;

   typedef struct packed {
      logic [1:0] spare;
      logic access_kind_hi;
      logic access_kind_lo;
      logic [`CSP_ADDR_W-1:0] addr;
   } csp_cmd_t;

   typedef struct packed {
      logic [`CSP_ADDR_W-1:0] addr;
      logic [`CSP_WORD_W-1:0] data;
   } csp_wr_t;

endpackage : csp_pkg

// File: csp_port.sv
// Purpose: Serial register port of a sigma-delta converter
// Assumes: sclk, cs_n, din, clock_edge_select, reset_n are asynchronous pins
// Notes: sclk is oversampled by clk_sys; sclk half period must exceed 3 clk_sys
//
// Contract
// - After reset, next transfer is command write
// - Command selects read or write and target
// - Access 01 gives one single read
// - Access 10 enters continuous read mode
// - Command access 11 or reset pin low leaves continuous read
// - Written bits collect until full count
// - Trim after eight clocks, filter after 24
// - Edge select high samples rising, else falling
// - Read start copies register into output shifter
// - Read bits leave on opposite edge
// - Falling chip select presents read MSB
// - Result-valid low on fresh data word
// - Result-valid high after data read completes
// - Result-valid high before each data update
// - Same data word readable again
// - Reset pin low holds ready high, ignores
`timescale 1ns/10ps
`include "csp_cfg.svh"

// ----------------------------------------
// Result buffer
// ----------------------------------------
module csp_fifo #(
   parameter int WIDTH = `CSP_WORD_W,
   parameter int DEPTH = `CSP_FIFO_DEPTH,
   parameter int AW = `CSP_FIFO_AW
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end
endmodule : csp_fifo

// ----------------------------------------
// Serial port
// ----------------------------------------
module csp_port (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic clock_edge_select,
   input wire logic reset_n,
   output logic dout,
   output logic dout_oe,
   output logic rdy_n,
   input wire logic conv_valid,
   output logic conv_ready,
   input wire logic [`CSP_WORD_W-1:0] conv_data,
   output logic [`CSP_ADDR_W-1:0] rd_addr,
   input wire logic [`CSP_WORD_W-1:0] rd_data,
   output logic wr_valid,
   output csp_pkg::csp_wr_t wr_word,
   output logic cont_mode
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [`CSP_PIN_N-1:0] pin_raw;
   logic [`CSP_PIN_N-1:0] sync1_q;
   logic [`CSP_PIN_N-1:0] sync2_q;
   logic sclk_prev_q;
   logic cs_prev_q;

   assign pin_raw = {reset_n, clock_edge_select, din, cs_n, sclk};

   for (genvar i = 0; i < `CSP_PIN_N; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            sync1_q[i] <= 1'b1;
            sync2_q[i] <= 1'b1;
         end else begin
            sync1_q[i] <= pin_raw[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sync2_q[0];
         cs_prev_q <= sync2_q[1];
      end
   end

   logic sclk_s;
   logic cs_s;
   logic din_s;
   logic pol_s;
   logic dev_rst;
   logic rise;
   logic fall;
   logic frame_on;
   logic samp;
   logic shft;
   logic cs_fall;

   assign sclk_s = sync2_q[0];
   assign cs_s = sync2_q[1];
   assign din_s = sync2_q[2];
   assign pol_s = sync2_q[3];
   assign dev_rst = ~sync2_q[4];
   assign rise = sclk_s & ~sclk_prev_q;
   assign fall = ~sclk_s & sclk_prev_q;
   assign frame_on = ~cs_s & ~dev_rst;
   assign samp = frame_on & (pol_s ? rise : fall);
   assign shft = frame_on & (pol_s ? fall : rise);
   assign cs_fall = frame_on & cs_prev_q;

   // ----------------------------------------
   // Register lengths
   // ----------------------------------------
   function automatic logic [`CSP_CNT_W-1:0] reg_len(input logic [`CSP_ADDR_W-1:0] a);
      logic [`CSP_CNT_W-1:0] n;
      n = `CSP_LEN_DEFAULT;
      case (a)
         `CSP_ADDR_MODE: n = `CSP_LEN_MODE;
         `CSP_ADDR_FILTER: n = `CSP_LEN_FILTER;
         `CSP_ADDR_TRIM: n = `CSP_LEN_TRIM;
         default: n = `CSP_LEN_DEFAULT;
      endcase
      return n;
   endfunction : reg_len

   // ----------------------------------------
   // Command engine
   // ----------------------------------------
   csp_pkg::csp_state_t st_q;
   csp_pkg::csp_state_t st_d;
   csp_pkg::csp_cmd_t cmd;
   logic [`CSP_CNT_W-1:0] bit_cnt_q;
   logic [`CSP_CNT_W-1:0] len_q;
   logic [`CSP_CNT_W-1:0] len_d;
   logic [`CSP_ADDR_W-1:0] addr_q;
   logic [`CSP_ADDR_W-1:0] addr_d;
   logic [`CSP_WORD_W-1:0] isr_q;
   logic [`CSP_WORD_W-1:0] din_word;
   logic word_done;
   logic restart;
   logic copy_req;
   logic wr_fire;
   logic rd_done;

   assign din_word = {isr_q[`CSP_WORD_W-2:0], din_s};
   assign word_done = samp && (bit_cnt_q == len_q - `CSP_CNT_W'(1));
   assign cmd = din_word[`CSP_CMD_W-1:0];

   always_comb begin
      st_d = st_q;
      len_d = len_q;
      addr_d = addr_q;
      copy_req = 1'b0;
      wr_fire = 1'b0;
      rd_done = 1'b0;
      restart = word_done;
      case (st_q)
         csp_pkg::CSP_ST_CMD: begin
            if (word_done) begin
               addr_d = cmd.addr;
               len_d = reg_len(cmd.addr);
               case ({cmd.access_kind_hi, cmd.access_kind_lo})
                  2'h0: st_d = csp_pkg::CSP_ST_WRITE;
                  2'h1: begin
                     st_d = csp_pkg::CSP_ST_READ;
                     copy_req = 1'b1;
                  end
                  2'h2: begin
                     st_d = csp_pkg::CSP_ST_CONT;
                     copy_req = 1'b1;
                  end
                  default: len_d = `CSP_LEN_CMD;
               endcase
            end
         end
         csp_pkg::CSP_ST_WRITE: begin
            if (word_done) begin
               wr_fire = 1'b1;
               st_d = csp_pkg::CSP_ST_CMD;
               len_d = `CSP_LEN_CMD;
            end
         end
         csp_pkg::CSP_ST_READ: begin
            if (word_done) begin
               rd_done = 1'b1;
               st_d = csp_pkg::CSP_ST_CMD;
               len_d = `CSP_LEN_CMD;
            end
         end
         csp_pkg::CSP_ST_CONT: begin
            if (samp && bit_cnt_q == `CSP_EXIT_CNT && din_word[`CSP_BIT_HI] && din_word[`CSP_BIT_LO]) begin
               st_d = csp_pkg::CSP_ST_CMD;
               len_d = `CSP_LEN_CMD;
               restart = 1'b1;
            end else if (word_done) begin
               rd_done = 1'b1;
               copy_req = 1'b1;
            end
         end
         default: begin
            st_d = csp_pkg::CSP_ST_CMD;
            len_d = `CSP_LEN_CMD;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= csp_pkg::CSP_ST_CMD;
         len_q <= `CSP_LEN_CMD;
         addr_q <= '0;
      end else if (dev_rst) begin
         st_q <= csp_pkg::CSP_ST_CMD;
         len_q <= `CSP_LEN_CMD;
         addr_q <= '0;
      end else begin
         st_q <= st_d;
         len_q <= len_d;
         addr_q <= addr_d;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= '0;
         isr_q <= '0;
      end else if (!frame_on || restart) begin
         bit_cnt_q <= '0;
         isr_q <= restart ? din_word : isr_q;
      end else if (samp) begin
         bit_cnt_q <= bit_cnt_q + `CSP_CNT_W'(1);
         isr_q <= din_word;
      end
   end

   // ----------------------------------------
   // Write strobe
   // ----------------------------------------
   logic [`CSP_WORD_W-1:0] wr_mask;

   assign wr_mask = ~(`CSP_WORD_W'('1) << len_q);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_valid <= 1'b0;
         wr_word <= '0;
      end else begin
         wr_valid <= wr_fire;
         if (wr_fire) begin
            wr_word <= {addr_q, din_word & wr_mask};
         end
      end
   end

   // ----------------------------------------
   // Output shifter
   // ----------------------------------------
   logic copy_pend_q;
   logic shown_q;
   logic hold_q;
   logic [`CSP_WORD_W-1:0] osr_q;
   logic [`CSP_WORD_W-1:0] data_q;
   logic [`CSP_WORD_W-1:0] src;
   logic [`CSP_CNT_W-1:0] pad;

   assign src = (addr_q == `CSP_ADDR_DATA) ? data_q : rd_data;
   assign pad = `CSP_CNT_W'(`CSP_WORD_W) - len_q;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         copy_pend_q <= 1'b0;
         shown_q <= 1'b0;
         hold_q <= 1'b0;
         osr_q <= '0;
         dout <= 1'b0;
      end else begin
         copy_pend_q <= copy_req & ~dev_rst;
         if (copy_pend_q) begin
            osr_q <= src << pad;
            shown_q <= 1'b0;
            hold_q <= 1'b0;
         end else if (cs_fall && !shown_q) begin
            dout <= osr_q[`CSP_WORD_W-1];
            shown_q <= 1'b1;
            hold_q <= (sclk_s == pol_s);
         end else if (shft && !shown_q) begin
            dout <= osr_q[`CSP_WORD_W-1];
            shown_q <= 1'b1;
         end else if (shft && hold_q) begin
            hold_q <= 1'b0;
         end else if (shft) begin
            osr_q <= osr_q << 1;
            dout <= osr_q[`CSP_WORD_W-2];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dout_oe <= 1'b0;
         rd_addr <= '0;
         cont_mode <= 1'b0;
      end else begin
         dout_oe <= ~cs_s;
         rd_addr <= addr_d;
         cont_mode <= (st_q == csp_pkg::CSP_ST_CONT);
      end
   end

   // ----------------------------------------
   // Data register and result-valid
   // ----------------------------------------
   logic fifo_valid;
   logic fifo_pop;
   logic pre_q;
   logic [`CSP_WORD_W-1:0] fifo_data;

   csp_fifo #(
      .WIDTH(`CSP_WORD_W),
      .DEPTH(`CSP_FIFO_DEPTH),
      .AW(`CSP_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(conv_valid),
      .in_ready(conv_ready),
      .in_data(conv_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign fifo_pop = pre_q && !copy_pend_q && !copy_req && !dev_rst;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_q <= 1'b0;
         rdy_n <= 1'b1;
         data_q <= `CSP_DATA_RST;
      end else if (dev_rst) begin
         pre_q <= 1'b0;
         rdy_n <= 1'b1;
      end else if (fifo_pop) begin
         data_q <= fifo_data;
         pre_q <= 1'b0;
         rdy_n <= 1'b0;
      end else if (fifo_valid && !pre_q) begin
         pre_q <= 1'b1;
         rdy_n <= 1'b1;
      end else if (rd_done && addr_q == `CSP_ADDR_DATA) begin
         rdy_n <= 1'b1;
      end
   end

endmodule : csp_port

// File: csp_port_monitor.sv
// Purpose: Checker of csp_port
// Assumes: Bound to csp_port
// Notes: One clock domain
`timescale 1ns/10ps
`include "csp_cfg.svh"
module csp_port_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic clock_edge_select,
   input wire logic reset_n,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic rdy_n,
   input wire logic conv_valid,
   input wire logic conv_ready,
   input wire logic [`CSP_WORD_W-1:0] conv_data,
   input wire logic [`CSP_ADDR_W-1:0] rd_addr,
   input wire logic [`CSP_WORD_W-1:0] rd_data,
   input wire logic wr_valid,
   input wire csp_pkg::csp_wr_t wr_word,
   input wire logic cont_mode
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // --------
   // Sequences
   // --------
   sequence s_held;
      !reset_n [*5];
   endsequence
   sequence s_push;
      conv_valid && conv_ready ##1 (reset_n && cs_n) [*8];
   endsequence
   // --------
   // Properties
   // --------
   property p_ready_hold;
      s_held |-> rdy_n;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("rdy_n low in reset");
   property p_wr_quiet;
      s_held |-> !wr_valid;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("write in reset");
   property p_wr_one;
      wr_valid |=> !wr_valid;
   endproperty
   a_wr_one: assert property (p_wr_one) else $error("long write pulse");
   property p_trim_len;
      wr_valid && wr_word.addr == `CSP_ADDR_TRIM |-> wr_word.data[23:8] == 16'h0000;
   endproperty
   a_trim_len: assert property (p_trim_len) else $error("trim too long");
   property p_mode_len;
      wr_valid && wr_word.addr == `CSP_ADDR_MODE |-> wr_word.data[23:16] == 8'h00;
   endproperty
   a_mode_len: assert property (p_mode_len) else $error("mode too long");
   property p_oe_cs;
      $stable(cs_n) [*5] |-> dout_oe == !cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs) else $error("dout_oe wrong");
   property p_pre_update;
      conv_valid && conv_ready |-> ##[1:3] rdy_n;
   endproperty
   a_pre_update: assert property (p_pre_update) else $error("no rise before update");
   property p_fresh;
      s_push |-> ##[0:3] !rdy_n;
   endproperty
   a_fresh: assert property (p_fresh) else $error("no fresh word");
endmodule : csp_port_monitor

// File: csp_host.sv
// Purpose: Host serial master model
// Assumes: Half period 160 ns
// Notes: Released data line shows inverse of last bit
`timescale 1ns/10ps
module csp_host (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   input wire logic clock_edge_select
);
   int half = 160;
   logic first_bit;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      first_bit = 1'b0;
   end
   task automatic xfer(input int n, input logic [23:0] wd, output logic [23:0] rd);
      rd = 24'h00_0000;
      sclk = clock_edge_select;
      #(2 * half + 7);
      cs_n = 1'b0;
      #(2 * half);
      first_bit = dout;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = ~clock_edge_select;
         din = wd[i];
         #(half);
         sclk = clock_edge_select;
         #(half);
         rd = {rd[22:0], dout};
      end
      cs_n = 1'b1;
      din = ~din;
      #(2 * half);
   endtask : xfer
endmodule : csp_host

// File: csp_port_bench.sv
// Purpose: Self-checking bench of csp_port
// Assumes: csp_host drives the serial pins
// Notes: Ends in report_and_stop
`timescale 1ns/10ps
module csp_port_bench;
   logic clk_sys, rst, reset_n, clock_edge_select, conv_valid;
   logic sclk, cs_n, din, dout, dout_oe, rdy_n, conv_ready, wr_valid, cont_mode;
   logic [23:0] conv_data, rd_data, rd;
   logic [3:0] rd_addr;
   csp_pkg::csp_wr_t wr_word, wr_seen;
   int fail_count = 0;
   int comparisons = 0;
   int wr_cnt = 0;
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   assign rd_data = {rd_addr, 20'h5_A3C1};
   always @(posedge clk_sys) begin
      if (wr_valid) begin
         wr_cnt <= wr_cnt + 1;
         wr_seen <= wr_word;
      end
   end
   csp_port dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .clock_edge_select(clock_edge_select), .reset_n(reset_n), .dout(dout), .dout_oe(dout_oe),
      .rdy_n(rdy_n), .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_word(wr_word), .cont_mode(cont_mode));
   csp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .clock_edge_select(clock_edge_select));
   // --------
   // Helpers
   // --------
   task automatic check(input string what, input logic [27:0] exp, input logic [27:0] seen);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic push(input logic [23:0] w);
      @(negedge clk_sys);
      conv_data = w;
      conv_valid = 1'b1;
      @(negedge clk_sys);
      conv_valid = 1'b0;
   endtask : push
   task automatic rd_word(input logic [7:0] cmd);
      host.xfer(8, {16'h0000, cmd}, rd);
      host.xfer(24, 24'h00_0000, rd);
   endtask : rd_word
   // --------
   // Tests
   // --------
   task automatic t_write;
      logic [7:0] cmd [3] = '{8'h03, 8'h04, 8'h02};
      logic [23:0] val [3] = '{24'hA5_C396, 24'h00_005A, 24'h00_C33C};
      int len [3] = '{24, 8, 16};
      int n;
      check("cont_reset", 1'b0, cont_mode);
      for (int i = 0; i < 3; i++) begin
         host.xfer(8, {16'h0000, cmd[i]}, rd);
         n = wr_cnt;
         host.xfer(len[i], val[i], rd);
         check("wr_count", 28'(n + 1), 28'(wr_cnt));
         check("wr_word", {cmd[i][3:0], val[i]}, wr_seen);
      end
      $display("test write done");
   endtask : t_write
   task automatic t_read;
      logic [23:0] w = 24'h3C_5AF0;
      int k;
      @(negedge clk_sys);
      clock_edge_select = 1'b0;
      push(w);
      for (k = 0; k < 400 && rdy_n !== 1'b0; k++) @(negedge clk_sys);
      check("rdy_low", 1'b0, rdy_n);
      for (int i = 0; i < 2; i++) begin
         rd_word(8'h11);
         check("read_data", w, rd);
         check("first_bit", w[23], host.first_bit);
         check("rdy_after", 1'b1, rdy_n);
      end
      rd_word(8'h13);
      check("reg_data", {4'h3, 20'h5_A3C1}, rd);
      check("rd_addr", 4'h3, rd_addr);
      $display("test read done");
   endtask : t_read
   task automatic t_cont;
      @(negedge clk_sys);
      clock_edge_select = 1'b1;
      host.xfer(8, 24'h00_0023, rd);
      check("cont_on", 1'b1, cont_mode);
      repeat (2) begin
         host.xfer(24, 24'h00_0000, rd);
         check("cont_data", {4'h3, 20'h5_A3C1}, rd);
      end
      check("cont_stay", 1'b1, cont_mode);
      host.xfer(8, 24'h00_0033, rd);
      check("cont_off", 1'b0, cont_mode);
      host.xfer(8, 24'h00_0004, rd);
      host.xfer(8, 24'h00_0077, rd);
      check("after_exit", {4'h4, 24'h00_0077}, wr_seen);
      $display("test continuous done");
   endtask : t_cont
   task automatic t_fill;
      int n;
      int run;
      n = wr_cnt;
      run = 0;
      @(negedge clk_sys);
      reset_n = 1'b0;
      for (int i = 0; i < 16; i++) push(24'h10_0000 + 24'(i));
      check("full", 1'b0, conv_ready);
      host.xfer(8, 24'h00_0004, rd);
      host.xfer(8, 24'h00_00EE, rd);
      check("ignored", 28'(n), 28'(wr_cnt));
      check("rdy_held", 1'b1, rdy_n);
      @(negedge clk_sys);
      reset_n = 1'b1;
      for (int k = 0; k < 400 && run < 4; k++) begin
         @(negedge clk_sys);
         run = (rdy_n === 1'b0) ? run + 1 : 0;
      end
      check("drained", 1'b1, conv_ready);
      rd_word(8'h11);
      check("last_word", 24'h10_000F, rd);
      $display("test buffer done");
   endtask : t_fill
   initial begin
      #1_000_000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      reset_n = 1'b1;
      clock_edge_select = 1'b1;
      conv_valid = 1'b0;
      conv_data = 24'h00_0000;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      t_write();
      t_read();
      t_cont();
      t_fill();
      report_and_stop();
   end
endmodule : csp_port_bench
bind csp_port csp_port_monitor mon (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
   .clock_edge_select(clock_edge_select), .reset_n(reset_n), .dout(dout), .dout_oe(dout_oe),
   .rdy_n(rdy_n), .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data),
   .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_word(wr_word), .cont_mode(cont_mode));
